// [rtl/sicr_pkg.sv]
/*
 * constants for the serial interface configuration register bank.
 * assumes a 10 MHz single clock and 15-bit register addresses.
 */
package sicr_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [14:0] OFS_IF_CFG = 15'h0000;
    localparam logic [14:0] OFS_DEV_CFG = 15'h0002;
    localparam logic [14:0] OFS_USER_SPI = 15'h0010;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_FULL_RESET = 7;
    localparam int BIT_ADDR_DIR = 5;
    localparam int BIT_SEP_OUT = 4;
    localparam int BIT_ADDR_FREEZE = 0;
    localparam logic [7:0] IF_CFG_RW_MASK = 8'h20;
    localparam logic [7:0] IF_CFG_RESET = 8'h30;
    localparam logic [7:0] DEV_CFG_RESET = 8'h00;
    localparam logic [7:0] USER_SPI_RESET = 8'h00;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h3;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SOFT_RESET_MAX_NS = 750;
    // longest time: round down
    localparam int SOFT_RESET_CYC = SOFT_RESET_MAX_NS / CLK_PERIOD_NS;
    localparam logic [3:0] SOFT_RESET_CNT = 4'(SOFT_RESET_CYC);
endpackage

// [rtl/sicr_regs.sv]
/*
 * interface configuration register bank with soft reset and streaming
 * address stepping. assumes an spi front end delivers decoded byte
 * accesses synchronous to ref_clk; the host stays idle during soft reset.
 */
`timescale 1ns/10ps
`default_nettype none

module sicr_regs (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // byte access from the spi front end
    input wire logic acc_start,
    input wire logic [14:0] acc_addr,
    input wire logic acc_byte,
    input wire logic acc_wr,
    input wire logic [7:0] acc_wdata,
    // answers
    output logic [7:0] acc_rdata,
    output logic [14:0] acc_cur_addr,
    output logic busy,
    // device control
    output logic chip_reset,
    output logic power_down
);
    typedef enum logic [1:0] {
        SICR_IDLE = 2'b01,
        SICR_RESET = 2'b10
    } sicr_state_e;

    sicr_state_e state_q;
    logic [3:0] cnt_q;
    logic [7:0] if_cfg_q;
    logic [7:0] dev_cfg_q;
    logic [7:0] user_spi_q;
    logic [14:0] addr_q;
    logic soft_rst;
    logic [14:0] eff_addr;
    logic wr_if;

    // ------------------------------------------------------------
    // soft reset sequencer
    // ------------------------------------------------------------
    assign eff_addr = acc_start ? acc_addr : addr_q;
    assign wr_if = acc_byte && acc_wr && state_q == SICR_IDLE
        && eff_addr == sicr_pkg::OFS_IF_CFG
        && acc_wdata[sicr_pkg::BIT_FULL_RESET];
    assign soft_rst = state_q == SICR_RESET;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_q <= SICR_IDLE;
            cnt_q <= 4'h0;
        end
        else if (wr_if)
        begin
            state_q <= SICR_RESET;
            cnt_q <= sicr_pkg::SOFT_RESET_CNT - 4'h1;
        end
        else if (state_q == SICR_RESET)
        begin
            if (cnt_q == 4'h0)
            begin
                state_q <= SICR_IDLE;
            end
            else
            begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            chip_reset <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            // held high until the counter runs out, then drops on its own
            chip_reset <= wr_if || (soft_rst && cnt_q != 4'h0);
            busy <= wr_if || (soft_rst && cnt_q != 4'h0);
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst || soft_rst)
        begin
            // the full reset bit always reads zero, so it clears itself
            if_cfg_q <= sicr_pkg::IF_CFG_RESET;
            dev_cfg_q <= sicr_pkg::DEV_CFG_RESET;
            user_spi_q <= sicr_pkg::USER_SPI_RESET;
        end
        else if (acc_byte && acc_wr)
        begin
            if (eff_addr == sicr_pkg::OFS_IF_CFG)
            begin
                // only the direction bit is stored; bit 4 stays one
                if_cfg_q <= (acc_wdata & sicr_pkg::IF_CFG_RW_MASK)
                    | (sicr_pkg::IF_CFG_RESET & ~sicr_pkg::IF_CFG_RW_MASK);
            end
            else if (eff_addr == sicr_pkg::OFS_DEV_CFG)
            begin
                dev_cfg_q <= acc_wdata;
            end
            else if (eff_addr == sicr_pkg::OFS_USER_SPI)
            begin
                user_spi_q <= acc_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // streaming address and read data
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst || soft_rst)
        begin
            addr_q <= 15'h0000;
        end
        else if (acc_byte)
        begin
            if (user_spi_q[sicr_pkg::BIT_ADDR_FREEZE])
            begin
                addr_q <= eff_addr;
            end
            else if (if_cfg_q[sicr_pkg::BIT_ADDR_DIR])
            begin
                addr_q <= eff_addr + 15'h0001;
            end
            else
            begin
                addr_q <= eff_addr - 15'h0001;
            end
        end
        else if (acc_start)
        begin
            addr_q <= acc_addr;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || soft_rst)
        begin
            acc_rdata <= 8'h00;
            acc_cur_addr <= 15'h0000;
            power_down <= 1'b0;
        end
        else
        begin
            acc_cur_addr <= eff_addr;
            power_down <= dev_cfg_q[1:0] == sicr_pkg::MODE_POWER_DOWN;
            if (eff_addr == sicr_pkg::OFS_IF_CFG)
            begin
                acc_rdata <= if_cfg_q;
            end
            else if (eff_addr == sicr_pkg::OFS_DEV_CFG)
            begin
                acc_rdata <= dev_cfg_q;
            end
            else if (eff_addr == sicr_pkg::OFS_USER_SPI)
            begin
                acc_rdata <= user_spi_q;
            end
            else
            begin
                acc_rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_reset_write;
        wr_if;
    endsequence

    sequence s_reset_done;
        ##[1:7] !chip_reset;
    endsequence

    property p_reset_bounded;
        @(posedge ref_clk) disable iff (rst) s_reset_write |=> chip_reset ##0 s_reset_done;
    endproperty

    a_reset_finishes: assert property (p_reset_bounded) else $error("soft reset too long");

    a_reset_launch: assert property (@(posedge ref_clk) disable iff (rst)
        wr_if |=> chip_reset) else $error("soft reset not launched");

    a_reset_selfclear: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(chip_reset) |-> if_cfg_q == sicr_pkg::IF_CFG_RESET)
        else $error("config not at reset value");

    a_if_after_reset: assert property (@(posedge ref_clk)
        rst |=> if_cfg_q == sicr_pkg::IF_CFG_RESET)
        else $error("if config reset wrong");

    a_dev_after_reset: assert property (@(posedge ref_clk)
        rst |=> dev_cfg_q == sicr_pkg::DEV_CFG_RESET)
        else $error("dev config reset wrong");

    a_sep_out_one: assert property (@(posedge ref_clk) disable iff (rst)
        if_cfg_q[sicr_pkg::BIT_SEP_OUT] && !if_cfg_q[sicr_pkg::BIT_FULL_RESET])
        else $error("read-only bits changed");

    a_step_dir: assert property (@(posedge ref_clk) disable iff (rst || soft_rst)
        acc_byte && !acc_start && !user_spi_q[0] && if_cfg_q[sicr_pkg::BIT_ADDR_DIR]
        |=> addr_q == $past(addr_q) + 15'h0001) else $error("address did not step up");

    a_freeze_hold: assert property (@(posedge ref_clk) disable iff (rst || soft_rst)
        acc_byte && user_spi_q[0] |=> addr_q == $past(eff_addr))
        else $error("frozen address moved");

    a_power_mode: assert property (@(posedge ref_clk) disable iff (rst || soft_rst)
        ##1 power_down == ($past(dev_cfg_q[1:0]) == sicr_pkg::MODE_POWER_DOWN))
        else $error("power down mismatch");
endmodule
`default_nettype wire

// [sim/sicr_host.sv]
/* spi host model issuing byte accesses to the register bank.
   assumes the bank samples on the rising edge of ref_clk. */
`timescale 1ns/10ps
`default_nettype none
module sicr_host (
    // clock and status
    input wire logic ref_clk,
    input wire logic busy,
    input wire logic [7:0] acc_rdata,
    // byte access
    output logic acc_start,
    output logic [14:0] acc_addr,
    output logic acc_byte,
    output logic acc_wr,
    output logic [7:0] acc_wdata
);
    initial
    begin
        acc_start = 1'b0;
        acc_addr = 15'h0000;
        acc_byte = 1'b0;
        acc_wr = 1'b0;
        acc_wdata = 8'h00;
    end
    // one byte per call; released address and data lines show inverted junk, not stale data
    task automatic xfer(input logic st, input logic [14:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] rd);
        int n;
        n = 0;
        while (busy === 1'b1 && n < 20)
        begin
            @(negedge ref_clk);
            n++;
        end
        acc_start = st;
        acc_addr = a;
        acc_byte = 1'b1;
        acc_wr = w;
        acc_wdata = (a == 15'h0000) ? (d & 8'hb0) : d;
        @(negedge ref_clk);
        rd = acc_rdata;
        acc_start = 1'b0;
        acc_byte = 1'b0;
        acc_wr = 1'b0;
        acc_addr = ~acc_addr;
        acc_wdata = ~acc_wdata;
        @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
/* self-checking bench for the register bank.
   assumes the host model in sicr_host and a 100 ns ref_clk. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic acc_start, acc_byte, acc_wr, busy, chip_reset, power_down;
    logic [14:0] acc_addr, acc_cur_addr;
    logic [7:0] acc_wdata, acc_rdata, rd;
    int n_errors = 0;
    int checked = 0;
    always #50 ref_clk = ~ref_clk;
    sicr_regs dut_u (.ref_clk(ref_clk), .rst(rst), .acc_start(acc_start),
        .acc_addr(acc_addr), .acc_byte(acc_byte), .acc_wr(acc_wr),
        .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_cur_addr(acc_cur_addr),
        .busy(busy), .chip_reset(chip_reset), .power_down(power_down));
    sicr_host host_u (.ref_clk(ref_clk), .busy(busy), .acc_rdata(acc_rdata),
        .acc_start(acc_start), .acc_addr(acc_addr), .acc_byte(acc_byte),
        .acc_wr(acc_wr), .acc_wdata(acc_wdata));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic t_defaults;
        host_u.xfer(1'b1, 15'h0000, 1'b0, 8'h00, rd);
        chk(rd, 8'h30, "if cfg reset");
        host_u.xfer(1'b1, 15'h0002, 1'b0, 8'h00, rd);
        chk(rd, 8'h00, "dev cfg reset");
        chk(8'(power_down), 8'h00, "power after reset");
        $display("test defaults done");
    endtask
    task automatic t_readonly;
        host_u.xfer(1'b1, 15'h0000, 1'b1, 8'h00, rd);
        host_u.xfer(1'b1, 15'h0000, 1'b0, 8'h00, rd);
        chk(rd, 8'h10, "indicator kept");
        host_u.xfer(1'b1, 15'h0000, 1'b1, 8'h20, rd);
        host_u.xfer(1'b1, 15'h0000, 1'b0, 8'h00, rd);
        chk(rd, 8'h30, "dir restored");
        $display("test readonly done");
    endtask
    task automatic t_modes;
        for (int m = 0; m < 4; m++)
        begin
            host_u.xfer(1'b1, 15'h0002, 1'b1, 8'(m), rd);
            chk(8'(power_down), 8'(m == 3), "power mode");
            host_u.xfer(1'b1, 15'h0002, 1'b0, 8'h00, rd);
            chk(rd, 8'(m), "mode field");
        end
        $display("test modes done");
    endtask
    // dev cfg holds 3 here, so a stepped read landing on 0x2 shows it
    task automatic t_stream;
        host_u.xfer(1'b1, 15'h0001, 1'b0, 8'h00, rd);
        host_u.xfer(1'b0, 15'h0000, 1'b0, 8'h00, rd);
        chk(rd, 8'h03, "step up");
        chk(8'(acc_cur_addr), 8'h03, "address after step up");
        host_u.xfer(1'b1, 15'h0000, 1'b1, 8'h00, rd);
        host_u.xfer(1'b1, 15'h0003, 1'b0, 8'h00, rd);
        host_u.xfer(1'b0, 15'h0000, 1'b0, 8'h00, rd);
        chk(rd, 8'h03, "step down");
        chk(8'(acc_cur_addr), 8'h01, "address after step down");
        host_u.xfer(1'b1, 15'h0010, 1'b1, 8'h01, rd);
        host_u.xfer(1'b1, 15'h0002, 1'b0, 8'h00, rd);
        host_u.xfer(1'b0, 15'h0000, 1'b0, 8'h00, rd);
        chk(rd, 8'h03, "frozen address");
        chk(8'(acc_cur_addr), 8'h02, "address held");
        host_u.xfer(1'b1, 15'h0010, 1'b1, 8'h00, rd);
        $display("test stream done");
    endtask
    task automatic t_soft;
        int n;
        n = 0;
        host_u.xfer(1'b1, 15'h0000, 1'b1, 8'h80, rd);
        repeat (12)
        begin
            @(negedge ref_clk);
            if (busy === 1'b1)
                n++;
            chk(8'(chip_reset), 8'(busy), "chip reset with busy");
        end
        // the write call itself already spent two falling edges of the interval
        chk(8'(n + 2), 8'(sicr_pkg::SOFT_RESET_CYC), "reset length");
        host_u.xfer(1'b1, 15'h0000, 1'b0, 8'h00, rd);
        chk(rd, 8'h30, "if cfg after soft reset");
        host_u.xfer(1'b1, 15'h0002, 1'b0, 8'h00, rd);
        chk(rd, 8'h00, "dev cfg after soft reset");
        chk(8'(power_down), 8'h00, "power after soft reset");
        $display("test soft reset done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        t_defaults();
        t_readonly();
        t_modes();
        t_stream();
        t_soft();
        end_sim();
    end
    // the tests need about 70 cycles; a hung handshake ends the run here
    initial
    begin
        #(2000 * 100);
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
